// file: core/exec_consts.vh
// Constants for the clear, call and decrement execution unit.
//
// Function
// - Watchdog-clear op resets the watchdog counter to zero.
// - Watchdog-clear op also clears the watchdog prescaler with a one-cycle pulse.
// - Watchdog-clear op sets timeout_status_n and powerdown_status_n to one, except that a timeout or sleep event in the same cycle clears its bit.
// - Call pushes the following address, program counter plus one, onto the stack.
// - Call loads its 11-bit operand into program counter bits 10 to 0.
// - Call takes program counter bits 12 and 11 from upper latch bits 4 and 3.
// - Call takes two instruction cycles and leaves every status flag alone.
// - Register operand is a 7-bit address; destination 0 writes accumulator, 1 writes register.
// - Invert op writes the inverted register to the destination, updating only zero.
// - Zero-register op writes zero to the register and sets the zero flag.
// - Minus-one op writes register minus one to the destination, updating only zero.
// - Zero-accumulator op writes zero to the accumulator and sets the zero flag.
// - Minus-one-skip op writes register minus one to the destination, flags untouched.
// - Minus-one-skip with zero result discards the fetched next op; two cycles.
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

`define OPC_WATCHDOG_CLEAR 14'h0064
`define OPC_CALL 3'h4
`define OPC_INVERT 6'h09
`define OPC_MINUS_ONE 6'h03
`define OPC_MINUS_ONE_SKIP 6'h0b
`define OPC_ZERO_REGISTER 7'h03
`define OPC_ZERO_ACCUMULATOR 7'h02
`define DEST_BIT 7
`define LATCH_HI_BIT 4
`define LATCH_LO_BIT 3

`define ALU_INVERT 2'h1
`define ALU_MINUS_ONE 2'h2
`define ALU_ZERO 2'h3

`define ADDR_CTRL 8'h00
`define ADDR_UPPER_LATCH 8'h04
`define ADDR_STATUS 8'h08
`define CTRL_ENABLE_RESET 1'h1
`define UPPER_LATCH_RESET 5'h00
`define ACCUMULATOR_RESET 8'h00
`define STATUS_Z_BIT 8
`define STATUS_TIMEOUT_BIT 9
`define STATUS_POWERDOWN_BIT 10

`endif

// file: core/exec_alu.v
// Small result generator for invert, minus-one and zero operations.
`timescale 1ns/100ps
`default_nettype none
`include "exec_consts.vh"

module exec_alu (
    input wire [1:0] sel,
    input wire [7:0] operand,
    output reg [7:0] result,
    output wire zero
);

    always @* begin
        case (sel)
            `ALU_INVERT: begin
                result = ~operand;
            end
            `ALU_MINUS_ONE: begin
                result = operand - 8'h01;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

    // Zero is judged on the full 8-bit result, so 8'h01 minus one gives 8'h00 and sets it.
    assign zero = (result == 8'h00);

endmodule
`default_nettype wire

// file: core/exec_unit.v
// Execution unit for watchdog clear, call, invert, clear and decrement ops with an APB register slave.
`timescale 1ns/100ps
`default_nettype none
`include "exec_consts.vh"

module exec_unit (
    input wire CLK,
    input wire RESET,

    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,

    input wire INSTR_VALID,
    input wire [13:0] INSTR,
    input wire [12:0] PC,
    input wire [7:0] REG_OPERAND,
    input wire TIMEOUT_EVENT,
    input wire SLEEP_EVENT,

    output wire REG_WE,
    output wire [6:0] REG_WADDR,
    output wire [7:0] REG_WDATA,
    output wire [7:0] ACCUMULATOR,
    output wire ZERO_FLAG,
    output wire TIMEOUT_STATUS_N,
    output wire POWERDOWN_STATUS_N,
    output wire WATCHDOG_CLEAR,
    output wire PRESCALER_CLEAR,
    output wire STACK_PUSH,
    output wire [12:0] STACK_TOP_DATA,
    output wire PC_LOAD,
    output wire [12:0] PC_TARGET,
    output wire DISCARD_NEXT
);

    localparam [1:0] ST_RUN = 2'b01;
    localparam [1:0] ST_FLUSH = 2'b10;

    ////////////////////////////////////////////////////////////////
    // Registers.

    reg [1:0] state_q;
    reg [1:0] state_d;

    reg [31:0] prdata_q;
    reg pready_q;
    reg pslverr_q;
    reg exec_en_q;
    reg [4:0] upper_latch_q;

    reg reg_we_q;
    reg [6:0] reg_waddr_q;
    reg [7:0] reg_wdata_q;
    reg [7:0] acc_q;
    reg zero_q;
    reg timeout_n_q;
    reg powerdown_n_q;
    reg watchdog_clear_q;
    reg prescaler_clear_q;
    reg stack_push_q;
    reg [12:0] stack_data_q;
    reg pc_load_q;
    reg [12:0] pc_target_q;
    reg discard_q;

    ////////////////////////////////////////////////////////////////
    // Decode.

    wire take;
    wire watchdog_clear_op;
    wire call_op;
    wire invert_register_op;
    wire register_minus_one_op;
    wire minus_one_skip_zero_op;
    wire zero_register_op;
    wire zero_accumulator_op;
    wire to_register;
    wire [7:0] alu_result;
    wire alu_zero;
    reg [1:0] alu_sel;

    // In the flush slot the fetched op is dropped, which is the no-operation cycle.
    assign take = INSTR_VALID & exec_en_q & (state_q == ST_RUN);

    assign watchdog_clear_op = (INSTR == `OPC_WATCHDOG_CLEAR);
    assign call_op = (INSTR[13:11] == `OPC_CALL);
    assign invert_register_op = (INSTR[13:8] == `OPC_INVERT);
    assign register_minus_one_op = (INSTR[13:8] == `OPC_MINUS_ONE);
    assign minus_one_skip_zero_op = (INSTR[13:8] == `OPC_MINUS_ONE_SKIP);
    assign zero_register_op = (INSTR[13:7] == `OPC_ZERO_REGISTER);
    assign zero_accumulator_op = (INSTR[13:7] == `OPC_ZERO_ACCUMULATOR);

    assign to_register = INSTR[`DEST_BIT];

    always @* begin
        if (invert_register_op) begin
            alu_sel = `ALU_INVERT;
        end else if (register_minus_one_op | minus_one_skip_zero_op) begin
            alu_sel = `ALU_MINUS_ONE;
        end else begin
            alu_sel = `ALU_ZERO;
        end
    end

    exec_alu u_alu (
        .sel(alu_sel),
        .operand(REG_OPERAND),
        .result(alu_result),
        .zero(alu_zero)
    );

    wire dest_op;
    wire skip_taken;
    wire two_cycle;

    assign dest_op = invert_register_op | register_minus_one_op | minus_one_skip_zero_op;
    assign skip_taken = minus_one_skip_zero_op & alu_zero;
    // A nonzero skip result leaves the slot open for the next op.
    assign two_cycle = take & (call_op | skip_taken);

    ////////////////////////////////////////////////////////////////
    // Pipeline slot control.

    always @* begin
        case (state_q)
            ST_RUN: begin
                if (two_cycle) begin
                    state_d = ST_FLUSH;
                end else begin
                    state_d = ST_RUN;
                end
            end
            ST_FLUSH: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (RESET) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Execution results.

    always @(posedge CLK) begin
        if (RESET) begin
            reg_we_q <= 1'b0;
            reg_waddr_q <= 7'h00;
            reg_wdata_q <= 8'h00;
            acc_q <= `ACCUMULATOR_RESET;
            zero_q <= 1'b0;
            timeout_n_q <= 1'b1;
            powerdown_n_q <= 1'b1;
            watchdog_clear_q <= 1'b0;
            prescaler_clear_q <= 1'b0;
            stack_push_q <= 1'b0;
            stack_data_q <= 13'h0000;
            pc_load_q <= 1'b0;
            pc_target_q <= 13'h0000;
            discard_q <= 1'b0;
        end else begin
            reg_we_q <= 1'b0;
            watchdog_clear_q <= 1'b0;
            prescaler_clear_q <= 1'b0;
            stack_push_q <= 1'b0;
            pc_load_q <= 1'b0;
            discard_q <= 1'b0;
            if (take) begin
                reg_waddr_q <= INSTR[6:0];
                reg_wdata_q <= alu_result;
                if ((dest_op & to_register) | zero_register_op) begin
                    reg_we_q <= 1'b1;
                end
                if ((dest_op & ~to_register) | zero_accumulator_op) begin
                    acc_q <= alu_result;
                end
                // The skip op and call leave the zero flag as it was.
                if (invert_register_op | register_minus_one_op) begin
                    zero_q <= alu_zero;
                end
                if (zero_register_op | zero_accumulator_op) begin
                    zero_q <= 1'b1;
                end
                if (watchdog_clear_op) begin
                    watchdog_clear_q <= 1'b1;
                    prescaler_clear_q <= 1'b1;
                end
                if (call_op) begin
                    stack_push_q <= 1'b1;
                    stack_data_q <= PC + 13'h0001;
                    pc_load_q <= 1'b1;
                    pc_target_q <= {upper_latch_q[`LATCH_HI_BIT:`LATCH_LO_BIT], INSTR[10:0]};
                end
                if (two_cycle) begin
                    discard_q <= 1'b1;
                end
            end
            // A timeout or sleep in the same cycle as a watchdog clear wins, so it is never lost.
            if (TIMEOUT_EVENT) begin
                timeout_n_q <= 1'b0;
            end else if (take & watchdog_clear_op) begin
                timeout_n_q <= 1'b1;
            end
            if (SLEEP_EVENT) begin
                powerdown_n_q <= 1'b0;
            end else if (take & watchdog_clear_op) begin
                powerdown_n_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // APB slave, one wait state per access.

    wire access;
    wire complete;
    wire [31:0] status_word;

    assign access = PSEL & PENABLE & ~pready_q;
    assign complete = PSEL & PENABLE & pready_q;

    assign status_word = {21'h000000, powerdown_n_q, timeout_n_q, zero_q, acc_q};

    always @(posedge CLK) begin
        if (RESET) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            exec_en_q <= `CTRL_ENABLE_RESET;
            upper_latch_q <= `UPPER_LATCH_RESET;
        end else begin
            pready_q <= access;
            pslverr_q <= 1'b0;
            if (access) begin
                case (PADDR)
                    `ADDR_CTRL: begin
                        prdata_q <= {31'h00000000, exec_en_q};
                    end
                    `ADDR_UPPER_LATCH: begin
                        prdata_q <= {27'h0000000, upper_latch_q};
                    end
                    `ADDR_STATUS: begin
                        prdata_q <= status_word;
                    end
                    default: begin
                        prdata_q <= 32'h00000000;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
            // Writes land only at the completing edge, so a held request never writes twice.
            if (complete & PWRITE) begin
                case (PADDR)
                    `ADDR_CTRL: begin
                        exec_en_q <= PWDATA[0];
                    end
                    `ADDR_UPPER_LATCH: begin
                        upper_latch_q <= PWDATA[4:0];
                    end
                    default: begin
                        exec_en_q <= exec_en_q;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs.

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign REG_WE = reg_we_q;
    assign REG_WADDR = reg_waddr_q;
    assign REG_WDATA = reg_wdata_q;
    assign ACCUMULATOR = acc_q;
    assign ZERO_FLAG = zero_q;
    assign TIMEOUT_STATUS_N = timeout_n_q;
    assign POWERDOWN_STATUS_N = powerdown_n_q;
    assign WATCHDOG_CLEAR = watchdog_clear_q;
    assign PRESCALER_CLEAR = prescaler_clear_q;
    assign STACK_PUSH = stack_push_q;
    assign STACK_TOP_DATA = stack_data_q;
    assign PC_LOAD = pc_load_q;
    assign PC_TARGET = pc_target_q;
    assign DISCARD_NEXT = discard_q;

endmodule
`default_nettype wire

// file: verification/exec_unit_monitor.sv
// Concurrent checks on the execution unit's instruction outputs.
`timescale 1ns/100ps
`default_nettype none
module exec_unit_monitor (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic INSTR_VALID,
    input wire logic [13:0] INSTR,
    input wire logic [12:0] PC,
    input wire logic [7:0] REG_OPERAND,
    input wire logic TIMEOUT_EVENT,
    input wire logic SLEEP_EVENT,
    input wire logic REG_WE,
    input wire logic [6:0] REG_WADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] ACCUMULATOR,
    input wire logic ZERO_FLAG,
    input wire logic TIMEOUT_STATUS_N,
    input wire logic POWERDOWN_STATUS_N,
    input wire logic WATCHDOG_CLEAR,
    input wire logic PRESCALER_CLEAR,
    input wire logic STACK_PUSH,
    input wire logic [12:0] STACK_TOP_DATA,
    input wire logic PC_LOAD,
    input wire logic [12:0] PC_TARGET,
    input wire logic DISCARD_NEXT
);
logic take_q;
logic [13:0] op_q;
logic [12:0] pc_q;
logic [7:0] arg_q;
logic en_q;
// Mirrors the enable bit from completed bus writes, since ops are ignored while it is low.
always_ff @(posedge CLK) begin
    if (RESET) en_q <= 1'b1;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00) en_q <= PWDATA[0];
end
// The slot after a two-cycle op is never taken, so it never counts as a cause.
always_ff @(posedge CLK) begin
    take_q <= !RESET && en_q && INSTR_VALID && !DISCARD_NEXT;
    op_q <= INSTR;
    pc_q <= PC;
    arg_q <= REG_OPERAND;
end
wire inv = op_q[13:8] == 6'h09;
wire dec = op_q[13:8] == 6'h03;
wire skp = op_q[13:8] == 6'h0b;
wire [7:0] res = inv ? ~arg_q : arg_q - 8'h01;
default clocking @(posedge CLK); endclocking
default disable iff (RESET);
sequence wd_s;
    en_q && INSTR_VALID && !DISCARD_NEXT && INSTR == 14'h0064;
endsequence
sequence call_s;
    en_q && INSTR_VALID && !DISCARD_NEXT && INSTR[13:11] == 3'h4;
endsequence
wd_clear_a: assert property (wd_s |=> WATCHDOG_CLEAR) else $error("wd");
presc_clear_a: assert property (wd_s |=> PRESCALER_CLEAR) else $error("presc");
wd_status_a: assert property (wd_s ##0 !TIMEOUT_EVENT && !SLEEP_EVENT
    |=> TIMEOUT_STATUS_N && POWERDOWN_STATUS_N) else $error("status");
call_push_a: assert property (call_s |=> STACK_PUSH && STACK_TOP_DATA == pc_q + 13'h1)
    else $error("push");
call_target_a: assert property (call_s |=> PC_LOAD && PC_TARGET[10:0] == op_q[10:0])
    else $error("target");
call_slot_a: assert property (call_s |=> DISCARD_NEXT && $stable(ZERO_FLAG)
    ##1 !STACK_PUSH && !REG_WE && $stable(ZERO_FLAG)) else $error("call slot");
dest_sel_a: assert property (take_q && (inv || dec || skp) |-> (op_q[7] ?
    REG_WE && REG_WADDR == op_q[6:0] && REG_WDATA == res : !REG_WE && ACCUMULATOR == res))
    else $error("dest");
zero_upd_a: assert property (take_q && (inv || dec) |-> ZERO_FLAG == (res == 8'h00))
    else $error("zero");
skip_flag_a: assert property (take_q && skp |-> $stable(ZERO_FLAG)) else $error("skip z");
skip_disc_a: assert property (take_q && skp |-> DISCARD_NEXT == (res == 8'h00))
    else $error("skip");
clr_reg_a: assert property (take_q && op_q[13:7] == 7'h03 |-> REG_WE && REG_WDATA == 8'h00
    && REG_WADDR == op_q[6:0] && ZERO_FLAG) else $error("clr reg");
clr_acc_a: assert property (take_q && op_q[13:7] == 7'h02
    |-> ACCUMULATOR == 8'h00 && ZERO_FLAG && !REG_WE) else $error("clr acc");
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Random and directed bench for the execution unit.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
logic INSTR_VALID = 0, TIMEOUT_EVENT = 0, SLEEP_EVENT = 0, pend = 0;
logic [7:0] PADDR = 0, REG_OPERAND = 0, REG_WDATA, ACCUMULATOR, acc = 0, v;
logic [31:0] PWDATA = 0, PRDATA, rd, r;
logic [13:0] INSTR = 0;
logic [12:0] PC = 0, STACK_TOP_DATA, PC_TARGET, top, tgt;
logic [6:0] REG_WADDR, wa;
logic PREADY, PSLVERR, REG_WE, ZERO_FLAG, TIMEOUT_STATUS_N, POWERDOWN_STATUS_N;
logic WATCHDOG_CLEAR, PRESCALER_CLEAR, STACK_PUSH, PC_LOAD, DISCARD_NEXT, er;
logic z = 0, to_n = 1, pd_n = 1, disc = 0, en = 1, e_we, e_wd, e_push;
logic [4:0] lat = 0;
integer fails = 0, tests_run = 0, seed = 32'hcf3b, n, k;
wire [5:0] pulses = {REG_WE, WATCHDOG_CLEAR, PRESCALER_CLEAR, STACK_PUSH, PC_LOAD, DISCARD_NEXT};
wire [10:0] state = {ACCUMULATOR, ZERO_FLAG, TIMEOUT_STATUS_N, POWERDOWN_STATUS_N};
exec_unit u_exec_unit (.*);
always #4 CLK = ~CLK;
////////////////////////////////////////////////////////////
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer t;
    t = 0;
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do begin
        @(posedge CLK);
        t++;
    end while (PREADY !== 1'b1 && t < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    // An idle edge keeps a following setup from driving PSEL twice in one step.
    @(posedge CLK);
endtask
function automatic logic [13:0] mk(input integer kk, input logic [31:0] x);
    case (kk)
        0: mk = 14'h0064;
        1: mk = {3'h4, x[10:0]};
        2: mk = {6'h09, x[7:0]};
        3: mk = {6'h03, x[7:0]};
        4: mk = {6'h0b, x[7:0]};
        5: mk = {7'h03, x[6:0]};
        default: mk = {7'h02, x[6:0]};
    endcase
endfunction
// Drives one op and advances the model at the edge that takes it.
task op(input integer kk, input logic [13:0] i, input logic [7:0] o, input logic [12:0] p, input logic [1:0] ev);
    logic drop;
    INSTR_VALID <= 1;
    INSTR <= i;
    REG_OPERAND <= o;
    PC <= p;
    {TIMEOUT_EVENT, SLEEP_EVENT} <= ev;
    @(posedge CLK);
    drop = disc || !en;
    v = kk == 2 ? ~o : kk > 4 ? 8'h00 : o - 8'h01;
    e_wd = !drop && kk == 0;
    e_push = !drop && kk == 1;
    e_we = !drop && kk > 1 && i[7];
    disc = !drop && (kk == 1 || (kk == 4 && v == 8'h00));
    if (!drop && kk > 1 && !i[7]) acc = v;
    if (!drop && kk > 1 && kk != 4) z = v == 8'h00;
    if (e_wd) {to_n, pd_n} = 2'b11;
    if (ev[1]) to_n = 0;
    if (ev[0]) pd_n = 0;
    wa = i[6:0];
    top = p + 13'h1;
    tgt = {lat[4:3], i[10:0]};
    pend = 1;
endtask
always @(negedge CLK) if (pend) begin
    pend = 0;
    `CHK("pulses", {e_we, e_wd, e_wd, e_push, e_push, disc}, pulses)
    `CHK("state", {acc, z, to_n, pd_n}, state)
    if (e_we) `CHK("write", {wa, v}, {REG_WADDR, REG_WDATA})
    if (e_push) `CHK("call", {top, tgt}, {STACK_TOP_DATA, PC_TARGET})
end
task finish_test;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
////////////////////////////////////////////////////////////
initial begin
    repeat (10) @(posedge CLK);
    RESET <= 0;
    apb(1, 8'h04, 32'h15);
    lat = 5'h15;
    apb(0, 8'h04, 0);
    `CHK("latch", 33'h15, {er, rd})
    apb(0, 8'h0c, 0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    op(1, 14'h27ff, 8'h00, 13'h1fff, 0);
    op(5, 14'h0185, 8'h33, 13'h0, 0);
    op(4, 14'h0b85, 8'h01, 13'h2, 0);
    op(2, 14'h0905, 8'hff, 13'h3, 0);
    op(4, 14'h0b05, 8'h02, 13'h4, 0);
    op(3, 14'h0305, 8'h00, 13'h5, 0);
    op(2, 14'h0985, 8'hff, 13'h6, 0);
    op(0, 14'h0064, 8'h00, 13'h7, 2'b11);
    op(0, 14'h0064, 8'h00, 13'h8, 0);
    op(6, 14'h0100, 8'h55, 13'h9, 0);
    op(5, 14'h01ff, 8'h55, 13'ha, 0);
    // With execution disabled every op must be ignored; the bus runs with no op offered.
    INSTR_VALID <= 0;
    apb(1, 8'h00, 0);
    en = 0;
    apb(0, 8'h00, 0);
    `CHK("ctrl", 33'h0, {er, rd})
    op(0, 14'h0064, 8'h00, 13'hb, 0);
    op(2, 14'h0905, 8'h00, 13'hc, 0);
    INSTR_VALID <= 0;
    apb(1, 8'h00, 1);
    en = 1;
    apb(0, 8'h00, 0);
    `CHK("ctrl", 33'h1, {er, rd})
    for (n = 0; n < 400; n++) begin
        r = $random(seed);
        k = r[31:29] % 7;
        op(k, mk(k, r), r[28] ? r[26:19] : {7'h0, r[27]} ^ {8{r[26]}}, r[12:0],
            {r[18:16] == 0, r[15:13] == 0});
    end
    INSTR_VALID <= 0;
    TIMEOUT_EVENT <= 0;
    SLEEP_EVENT <= 0;
    @(posedge CLK);
    apb(0, 8'h08, 0);
    `CHK("status", {21'h0, pd_n, to_n, z, acc}, rd)
    finish_test;
end
// The whole run needs well under 3000 cycles; this allows ample margin.
initial begin
    #100000;
    fails++;
    finish_test;
end
endmodule
bind exec_unit exec_unit_monitor u_exec_unit_monitor (.*);
`default_nettype wire
